// *** eecmd_engine.sv ***
// Purpose: device-side command engine of a three-wire serial eeprom
// Assumes: select, serial clock, data in and width strap arrive asynchronously
// Notes: serial clock is oversampled by ref_clk; its period must exceed several ref_clk cycles
`timescale 1ns/1ps
`default_nettype none
module eecmd_engine
  import eecmd_pkg::*;
#(
  parameter int ADDR_W16 = eecmd_pkg::ADDR_W16_DEF,
  parameter int PROG_CYCLES = eecmd_pkg::PROG_CYCLES_DEF
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic chip_enable_line,
  input wire logic bit_timing_input,
  input wire logic serial_in,
  input wire logic width_select,
  output logic serial_out,
  output logic serial_out_oe_n,
  output logic busy
);
  import eecmd_pkg::*;

  localparam int AW8 = ADDR_W16 + 1;
  localparam int NBYTES = 2 ** AW8;

  eecmd_state_t state_r;
  logic [1:0] cs_q_r, clk_q_r, din_q_r, org_q_r;
  logic clk_d_r, cs_d_r;
  logic org8_r, wel_r, ready_r, pend_clr_r, pend_all_r;
  logic [1:0] op_r;
  logic [AW8-1:0] addr_r;
  logic [15:0] data_r, rd_sh_r;
  logic [CNT_W-1:0] bitcnt_r;
  logic [4:0] rd_left_r;
  logic [$clog2(STATUS_VALID_CYC+1)-1:0] slsh_cnt_r;
  logic [$clog2(PROG_CYCLES+1)-1:0] prog_cnt_r;
  logic serial_out_r, oe_n_r;
  logic [7:0] mem_r [NBYTES];

  // two-stage synchronisers; only the second stage is looked at
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_q_r <= 2'h0;
      clk_q_r <= 2'h0;
      din_q_r <= 2'h0;
      org_q_r <= 2'h3;
      cs_d_r <= 1'b0;
      clk_d_r <= 1'b0;
    end else begin
      cs_q_r <= {cs_q_r[0], chip_enable_line};
      clk_q_r <= {clk_q_r[0], bit_timing_input};
      din_q_r <= {din_q_r[0], serial_in};
      org_q_r <= {org_q_r[0], width_select};
      cs_d_r <= cs_q_r[1];
      clk_d_r <= clk_q_r[1];
    end
  end

  // edge and field decode
  wire cs_s = cs_q_r[1];
  wire din_s = din_q_r[1];
  wire clk_rise = clk_q_r[1] & ~clk_d_r;
  wire cs_rise = cs_s & ~cs_d_r;
  wire cs_fall = ~cs_s & cs_d_r;
  wire [CNT_W-1:0] aw_w = org8_r ? CNT_W'(AW8) : CNT_W'(ADDR_W16);
  wire [CNT_W-1:0] dw_w = org8_r ? CNT_W'(DATA_W8) : CNT_W'(DATA_W16);
  wire addr_end = bitcnt_r == (CNT_W'(OP_BITS) + aw_w);
  wire data_end = bitcnt_r == (CNT_W'(OP_BITS) + aw_w + dw_w);
  wire [1:0] ext_w = org8_r ? addr_r[AW8-1 -: 2] : addr_r[ADDR_W16-1 -: 2];
  wire dec_w = (state_r == S_ADDR) & addr_end;
  wire is_read = dec_w & (op_r == OP_READ);
  wire is_unlock = dec_w & (op_r == OP_EXT) & (ext_w == EXT_UNLOCK);
  wire is_lock = dec_w & (op_r == OP_EXT) & (ext_w == EXT_LOCK);
  wire is_clear = dec_w & (op_r == OP_EXT) & (ext_w == EXT_CLEAR);
  wire is_fill = dec_w & (op_r == OP_EXT) & (ext_w == EXT_FILL);
  wire is_erase = dec_w & (op_r == OP_ERASE);
  wire is_write = dec_w & (op_r == OP_WRITE);
  wire slsh_done = slsh_cnt_r == $bits(slsh_cnt_r)'(STATUS_VALID_CYC);
  wire prog_end = (state_r == S_PROG) & (prog_cnt_r == $bits(prog_cnt_r)'(PROG_CYCLES - 1));
  wire launch = (state_r == S_ARMED) & cs_fall & wel_r;

  // address stepping for sequential reads; word mode masks the spare top bit
  wire [AW8-1:0] addr_mask = org8_r ? {AW8{1'b1}} : {1'b0, {ADDR_W16{1'b1}}};
  wire [AW8-1:0] addr_inc = (addr_r + AW8'(1)) & addr_mask;
  wire [AW8-1:0] rd_addr = (state_r == S_READ) ? addr_inc : addr_r;
  wire [AW8-1:0] rd_i0 = org8_r ? rd_addr : {rd_addr[ADDR_W16-1:0], 1'b0};
  wire [AW8-1:0] rd_i1 = {rd_addr[ADDR_W16-1:0], 1'b1};
  wire [15:0] rd_word = org8_r ? {mem_r[rd_i0], 8'h00} : {mem_r[rd_i0], mem_r[rd_i1]};

  // main sequencer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= S_IDLE;
      org8_r <= 1'b0;
      op_r <= 2'h0;
      addr_r <= '0;
      data_r <= 16'h0000;
      bitcnt_r <= '0;
      pend_clr_r <= 1'b0;
      pend_all_r <= 1'b0;
      prog_cnt_r <= '0;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (cs_rise & ~clk_q_r[1]) state_r <= S_START;
        end
        S_START: begin
          if (!cs_s) state_r <= S_IDLE;
          else if (clk_rise & din_s) begin
            state_r <= S_ADDR;
            org8_r <= ~org_q_r[1];
            bitcnt_r <= '0;
          end
        end
        S_ADDR, S_DATA: begin
          if (!cs_s) state_r <= S_IDLE;
          else if (clk_rise) begin
            bitcnt_r <= bitcnt_r + CNT_W'(1);
            if (bitcnt_r < CNT_W'(OP_BITS)) op_r <= {op_r[0], din_s};
            else if (state_r == S_ADDR) addr_r <= {addr_r[AW8-2:0], din_s};
            else data_r <= {data_r[14:0], din_s};
          end else if (is_read) state_r <= S_READ;
          else if (is_unlock | is_lock) state_r <= S_IGNORE;
          else if (is_erase | is_clear) begin
            state_r <= S_ARMED;
            pend_clr_r <= 1'b1;
            pend_all_r <= is_clear;
          end else if (is_write | is_fill) begin
            state_r <= S_DATA;
            pend_clr_r <= 1'b0;
            pend_all_r <= is_fill;
          end else if ((state_r == S_DATA) & data_end) state_r <= S_ARMED;
        end
        S_READ: begin
          if (!cs_s) state_r <= S_IDLE;
          else if (clk_rise & (rd_left_r == 5'h1)) addr_r <= addr_inc;
        end
        S_ARMED: begin
          if (cs_fall) state_r <= wel_r ? S_PROG : S_IDLE;
          else if (clk_rise) state_r <= S_IGNORE;
          prog_cnt_r <= '0;
        end
        S_PROG: begin
          prog_cnt_r <= prog_cnt_r + $bits(prog_cnt_r)'(1);
          if (prog_end) state_r <= cs_s ? S_START : S_IDLE;
        end
        S_IGNORE: begin
          if (!cs_s) state_r <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // write-enable latch: only unlock and lock touch it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) wel_r <= WEL_RESET;
    else if (is_unlock) wel_r <= 1'b1;
    else if (is_lock) wel_r <= 1'b0;
  end

  // status delay: counts select-high time so status is not shown too early
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) slsh_cnt_r <= '0;
    else if (!cs_s) slsh_cnt_r <= '0;
    else if (!slsh_done) slsh_cnt_r <= slsh_cnt_r + $bits(slsh_cnt_r)'(1);
  end

  // ready flag: set at completion, dropped by deselect or a new start bit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) ready_r <= 1'b0;
    else if (prog_end) ready_r <= 1'b1;
    else if (cs_fall | (state_r == S_START & clk_rise & din_s)) ready_r <= 1'b0;
  end

  // array storage; erase-then-write collapses to the final value at completion,
  // so a location is never seen half written from the serial side
  genvar gi;
  generate
    for (gi = 0; gi < NBYTES; gi++) begin : g_mem
      localparam logic [AW8-1:0] IDX = AW8'(gi);
      wire hit = pend_all_r | (org8_r ? (IDX == addr_r) : (IDX[AW8-1:1] == addr_r[ADDR_W16-1:0]));
      wire [7:0] wval = pend_clr_r ? ERASED_BYTE :
                        (org8_r | IDX[0]) ? data_r[7:0] : data_r[15:8];
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) mem_r[gi] <= ERASED_BYTE;
        else if (prog_end & hit) mem_r[gi] <= wval;
      end
    end
  endgenerate

  // output shifter and pin drive
  wire stat_drive = cs_s & slsh_done & ((state_r == S_PROG) | ready_r);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_sh_r <= 16'h0000;
      rd_left_r <= 5'h0;
      serial_out_r <= 1'b0;
      oe_n_r <= 1'b1;
    end else begin
      oe_n_r <= ~(is_read | (state_r == S_READ & cs_s) | stat_drive);
      if (is_read) begin
        serial_out_r <= 1'b0;
        rd_sh_r <= rd_word;
        rd_left_r <= 5'(dw_w);
      end else if (state_r == S_READ) begin
        if (clk_rise) begin
          serial_out_r <= rd_sh_r[15];
          rd_sh_r <= (rd_left_r == 5'h1) ? rd_word : {rd_sh_r[14:0], 1'b0};
          rd_left_r <= (rd_left_r == 5'h1) ? 5'(dw_w) : rd_left_r - 5'h1;
        end
      end else begin
        serial_out_r <= (state_r != S_PROG) & ready_r;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) busy <= 1'b0;
    else busy <= (state_r == S_PROG) & ~prog_end;
  end
  assign serial_out = serial_out_r;
  assign serial_out_oe_n = oe_n_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  AST_WEL_SET: assert property ($rose(wel_r) |-> $past(is_unlock))
    else $error("latch set without unlock");
  AST_WEL_CLR: assert property ($fell(wel_r) |-> $past(is_lock))
    else $error("latch cleared without lock");
  AST_NO_LAUNCH_LOCKED: assert property ((state_r == S_ARMED && cs_fall && !wel_r) |=> state_r == S_IDLE)
    else $error("modify launched while locked");
  AST_DUMMY_ZERO: assert property ((is_read && cs_s && !clk_rise) |=> (state_r == S_READ && !serial_out_r && !serial_out_oe_n))
    else $error("read did not start with dummy zero");
  AST_OUT_ON_EDGE: assert property ((state_r == S_READ && $past(state_r) == S_READ && $changed(serial_out_r)) |-> $past(clk_rise))
    else $error("read data moved without clock edge");
  AST_WRAP: assert property ((state_r == S_READ && cs_s && clk_rise && rd_left_r == 5'h1) |=> addr_r == $past(addr_inc))
    else $error("sequential address step wrong");
  AST_EXTRA_CLK_ABORT: assert property ((state_r == S_ARMED && clk_rise && !cs_fall) |=> state_r == S_IGNORE ##1 !prog_end)
    else $error("extra clock did not abort");
  AST_LAUNCH: assert property (launch |=> state_r == S_PROG [*3])
    else $error("programming not self-timed");
  AST_BUSY_LOW: assert property ((state_r == S_PROG && stat_drive && !prog_end) |=> (!serial_out && !serial_out_oe_n))
    else $error("busy not shown low");
  AST_READY_HIGH: assert property ((ready_r && cs_s && slsh_done && state_r != S_READ && !is_read) |=> (serial_out && !serial_out_oe_n))
    else $error("ready not shown high");
endmodule // eecmd_engine
`default_nettype wire

// *** eecmd_engine_bench.sv ***
// Purpose: self-checking bench of the serial eeprom command engine
// Assumes: short program cycle of 50 clocks; x8 address 7 bits, x16 address 6 bits
// Notes: expected bytes follow from the frames sent, never from the engine
`timescale 1ns/1ps
`default_nettype none
module eecmd_engine_bench;
  import eecmd_pkg::*;
  logic ref_clk, rst_n, width_select, sel, sclk, din, serial_out, serial_out_oe_n, busy;
  wire pin_q;
  int bad_count = 0;
  int check_count = 0;
  // a released pin shows the opposite of the last driven value, so a missing enable is caught
  assign pin_q = serial_out_oe_n ? ~serial_out : serial_out;
  eecmd_host eecmd_host_inst (.sel(sel), .sclk(sclk), .din(din), .dout(pin_q));
  eecmd_engine #(.PROG_CYCLES(50)) eecmd_engine_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .chip_enable_line(sel), .bit_timing_input(sclk),
    .serial_in(din), .width_select(width_select), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n), .busy(busy));
  // 125 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // modifying frame; when it should start, check busy status, completion and ready
  task automatic prog(input logic [31:0] v, input int n, input int extra, input logic exp);
    logic s;
    eecmd_host_inst.cmd(v, n, extra);
    chk(busy, exp);
    if (exp) begin
      eecmd_host_inst.stat(s);
      chk(s, 1'b0);
      for (int i = 0; i < 200 && busy !== 1'b0; i++) @(negedge ref_clk);
      chk(busy, 1'b0);
      eecmd_host_inst.stat(s);
      chk(s, 1'b1);
    end
  endtask
  // read n bytes in one x8 frame starting at a
  task automatic rd8(input logic [6:0] a, input int n, input logic [31:0] exp);
    logic dm;
    logic [31:0] q;
    eecmd_host_inst.rd({1'b1, OP_READ, a}, 10, 8 * n, dm, q);
    chk(dm, 1'b0);
    chk(q, exp);
  endtask
  task automatic t_blank;
    rd8(7'h05, 2, 32'hffff);
    $display("blank read done");
  endtask
  task automatic t_locked;
    prog({1'b1, OP_WRITE, 7'h03, 8'h5a}, 18, 0, 1'b0);
    rd8(7'h03, 1, 32'hff);
    $display("locked write done");
  endtask
  task automatic t_write;
    eecmd_host_inst.cmd({1'b1, OP_EXT, EXT_UNLOCK, 5'h00}, 10, 0);
    prog({1'b1, OP_WRITE, 7'h03, 8'h5a}, 18, 0, 1'b1);
    rd8(7'h02, 3, 32'hff5aff);
    $display("write done");
  endtask
  task automatic t_count;
    prog({1'b1, OP_WRITE, 7'h04, 8'h33}, 18, 1, 1'b0);
    prog({1'b1, OP_WRITE, 7'h04, 8'h33} >> 1, 17, 0, 1'b0);
    rd8(7'h04, 1, 32'hff);
    $display("pulse count done");
  endtask
  task automatic t_fill;
    prog({1'b1, OP_EXT, EXT_FILL, 5'h00, 8'h96}, 18, 0, 1'b1);
    prog({1'b1, OP_WRITE, 7'h10, 8'h69}, 18, 0, 1'b1);
    rd8(7'h10, 1, 32'h69);
    prog({1'b1, OP_ERASE, 7'h7f}, 10, 0, 1'b1);
    rd8(7'h7f, 2, 32'hff96);
    prog({1'b1, OP_EXT, EXT_CLEAR, 5'h00}, 10, 0, 1'b1);
    rd8(7'h00, 1, 32'hff);
    $display("fill and erase done");
  endtask
  task automatic t_wide;
    logic dm;
    logic [31:0] q;
    width_select = 1'b1;
    eecmd_host_inst.cmd({1'b1, OP_EXT, EXT_UNLOCK, 4'h0}, 9, 0);
    prog({1'b1, OP_WRITE, 6'h02, 16'h1234}, 25, 0, 1'b1);
    eecmd_host_inst.rd({1'b1, OP_READ, 6'h02}, 9, 16, dm, q);
    chk(dm, 1'b0);
    chk(q, 32'h1234);
    width_select = 1'b0;
    rd8(7'h04, 2, 32'h1234);
    eecmd_host_inst.cmd({1'b1, OP_EXT, EXT_LOCK, 5'h00}, 10, 0);
    prog({1'b1, OP_WRITE, 7'h05, 8'h00}, 18, 0, 1'b0);
    rd8(7'h04, 2, 32'h1234);
    $display("word mode done");
  endtask
  // reset, then the scenarios in an order where each leaves a known array
  initial begin
    rst_n = 1'b0;
    width_select = 1'b0;
    repeat (4) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    t_blank();
    t_locked();
    t_write();
    t_count();
    t_fill();
    t_wide();
    report_and_stop();
  end
  // watchdog well beyond the roughly 35 us that the frames take
  initial begin
    #400000;
    bad_count++;
    report_and_stop();
  end
endmodule // eecmd_engine_bench
`default_nettype wire

// *** eecmd_host.sv ***
// Purpose: host model that drives select, serial clock and data in of the engine
// Assumes: tasks are entered at a ref_clk falling edge; serial clock period 64 ns
// Notes: serial clock stands low between frames; idle data in flips so stale bits never match
`timescale 1ns/1ps
`default_nettype none
module eecmd_host (
  output var logic sel,
  output var logic sclk,
  output var logic din,
  input wire logic dout
);
  // bus idle at time zero
  initial begin
    sel = 1'b0;
    sclk = 1'b0;
    din = 1'b0;
  end
  // open with the clock low, then shift msb first; data changes only while the clock is low
  task automatic shift(input logic [31:0] v, input int n);
    sel = 1'b1;
    #64;
    for (int i = n - 1; i >= 0; i--) begin
      din = v[i];
      #32 sclk = 1'b1;
      #32 sclk = 1'b0;
    end
  endtask
  // extra edges break the pulse count on purpose; select drops inside the last low phase
  task automatic cmd(input logic [31:0] v, input int n, input int extra);
    shift(v, n);
    repeat (extra) begin
      #32 sclk = 1'b1;
      #32 sclk = 1'b0;
    end
    #16 sel = 1'b0;
    din = ~din;
    #48;
  endtask
  // sample each read bit late in the low phase, where it has settled
  task automatic rd(input logic [31:0] v, input int n, input int nb, output logic dm,
                    output logic [31:0] q);
    q = '0;
    shift(v, n);
    #32 dm = dout;
    for (int i = 0; i < nb; i++) begin
      sclk = 1'b1;
      #32 sclk = 1'b0;
      #32 q = {q[30:0], dout};
    end
    sel = 1'b0;
    din = ~din;
    #64;
  endtask
  // select alone, long enough for the status to become valid
  task automatic stat(output logic s);
    sel = 1'b1;
    #128 s = dout;
    sel = 1'b0;
    #64;
  endtask
endmodule // eecmd_host
`default_nettype wire

// *** eecmd_pkg.sv ***
// Purpose: shared constants of the serial eeprom command engine
// Assumes: 125 MHz ref_clk; timings given in ns and turned into cycle counts here
// Notes: array size set by the x16 address width, the x8 address is one bit wider
`default_nettype none
package eecmd_pkg;
  // clock
  localparam int CLK_PERIOD_NS = 8;
  // organization and field widths
  localparam int ADDR_W16_DEF = 6;
  localparam int DATA_W8 = 8;
  localparam int DATA_W16 = 16;
  localparam int OP_BITS = 2;
  localparam int CNT_W = 6;
  // op-codes and the extended op-codes held in the top two address bits
  localparam logic [1:0] OP_EXT = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] EXT_LOCK = 2'h0;
  localparam logic [1:0] EXT_FILL = 2'h1;
  localparam logic [1:0] EXT_CLEAR = 2'h2;
  localparam logic [1:0] EXT_UNLOCK = 2'h3;
  // reset values
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic WEL_RESET = 1'b0;
  // timings: self-timed program cycle and status_valid_delay
  localparam int PROG_TIME_NS = 5000000;
  localparam int PROG_CYCLES_DEF = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STATUS_VALID_NS = 50;
  localparam int STATUS_VALID_CYC = (STATUS_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // engine states
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_START = 3'h1,
    S_ADDR = 3'h2,
    S_DATA = 3'h3,
    S_READ = 3'h4,
    S_ARMED = 3'h5,
    S_PROG = 3'h6,
    S_IGNORE = 3'h7
  } eecmd_state_t;
endpackage
`default_nettype wire
